// ---- logic/anr_if.sv ----
`timescale 1ns/1ns
interface anr_if;
   logic [15:0] advert_reg;
   logic [15:0] partner_reg;
   logic [4:0]  addr;
   logic [15:0] rd_word;
   modport regs (input advert_reg, input partner_reg, input addr,
                 output rd_word);
   modport mux  (output advert_reg, output partner_reg, output addr,
                 input rd_word);
endinterface

// ---- logic/anr_pkg.sv ----
package anr_pkg;
   // register indices on the management port
   localparam logic [4:0]  ADDR_LOCAL_ADVERT    = 5'h04;
   localparam logic [4:0]  ADDR_PARTNER_ABILITY = 5'h05;
   localparam logic [15:0] LOCAL_ADVERT_RST     = 16'h01E1;
   localparam logic [15:0] PARTNER_ABILITY_RST  = 16'h0000;
   // field positions
   localparam int ABIL_MSB   = 8;
   localparam int ABIL_LSB   = 5;
   localparam int RFAULT_BIT = 13;
   localparam int NPAGE_BIT  = 15;
   localparam int ACK_BIT    = 14;
   localparam int PTECH_MSB  = 12;
   localparam int PTECH_LSB  = 5;
   localparam int SEL_MSB    = 4;
   localparam logic [4:0]  SELECTOR_CODE = 5'h01;
   localparam logic [15:0] ADVERT_WR_MASK = 16'h21E0;

   typedef struct packed {
      logic [15:0] advert_reg;
      logic [15:0] advert_live;
      logic [15:0] partner;
      logic [15:0] rd_data;
      logic        restart_s1;
      logic        restart_s2;
      logic        restart_s3;
      logic        pvalid_s1;
      logic        pvalid_s2;
      logic        pvalid_s3;
   } anr_state_t;
endpackage

// ---- logic/anr_read_mux.sv ----
`timescale 1ns/1ns
module anr_read_mux
   import anr_pkg::*;
(
   anr_if.regs bus
);
   // =====================================================
   // read decode; unmapped indices read as zero
   always_comb begin
      case (bus.addr)
         ADDR_LOCAL_ADVERT:    bus.rd_word = bus.advert_reg;
         ADDR_PARTNER_ABILITY: bus.rd_word = bus.partner_reg;
         default:              bus.rd_word = 16'h0000;
      endcase
   end
endmodule

// ---- logic/anr_regs.sv ----
`timescale 1ns/1ns
module anr_regs
   import anr_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        nrst_i,
   input  wire logic [4:0]  reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic [15:0] reg_wdata_i,
   output logic      [15:0] reg_rdata_o,
   input  wire logic        an_restart_i,
   input  wire logic        partner_valid_i,
   input  wire logic [15:0] partner_page_i,
   output logic      [15:0] advert_live_o,
   output logic      [15:0] advert_reg_o,
   output logic             ability_fast_full_o,
   output logic             ability_fast_half_o,
   output logic             ability_slow_full_o,
   output logic             ability_slow_half_o
);
   import anr_pkg::*;

   anr_state_t st_ff;
   anr_state_t nxt_st;
   anr_if      rbus ();
   logic [15:0] page_q;

   // =====================================================
   // helpers
   // rising edge seen between the second and third stages, so the
   // pulse is one clock long however long the pin stays high
   function automatic logic anr_rise(input logic s2, input logic s3);
      return s2 && !s3;
   endfunction

   // only the writable bits follow the bus; the rest keep their value
   function automatic logic [15:0] anr_merge(input logic [15:0] wr_word,
                                            input logic [15:0] old_word);
      return (wr_word & ADVERT_WR_MASK) | (old_word & ~ADVERT_WR_MASK);
   endfunction

   // write strobe aimed at one register index
   function automatic logic anr_hit(input logic       wr,
                                    input logic [4:0] addr,
                                    input logic [4:0] idx);
      return wr && (addr == idx);
   endfunction

   // =====================================================
   // read path
   assign rbus.addr        = reg_addr_i;
   assign rbus.advert_reg  = st_ff.advert_reg;
   assign rbus.partner_reg = st_ff.partner;

   anr_read_mux u_mux (
      .bus (rbus)
   );

   // page word is held steady by the link side while valid is high;
   // page_q registers it every clock; the partner register takes page_q once the valid edge has passed two stages
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         page_q <= PARTNER_ABILITY_RST;
      end else begin
         page_q <= partner_page_i;
      end
   end

   // =====================================================
   // next state
   always_comb begin
      nxt_st = st_ff;
      nxt_st.restart_s1 = an_restart_i;
      nxt_st.restart_s2 = st_ff.restart_s1;
      nxt_st.restart_s3 = st_ff.restart_s2;
      nxt_st.pvalid_s1  = partner_valid_i;
      nxt_st.pvalid_s2  = st_ff.pvalid_s1;
      nxt_st.pvalid_s3  = st_ff.pvalid_s2;
      nxt_st.rd_data    = rbus.rd_word;
      if (anr_hit(reg_wr_i, reg_addr_i, ADDR_LOCAL_ADVERT)) begin
         nxt_st.advert_reg = anr_merge(reg_wdata_i, st_ff.advert_reg);
      end
      nxt_st.advert_reg[SEL_MSB:0] = SELECTOR_CODE;
      if (anr_rise(st_ff.restart_s2, st_ff.restart_s3)) begin
         nxt_st.advert_live = st_ff.advert_reg;
      end
      if (anr_rise(st_ff.pvalid_s2, st_ff.pvalid_s3)) begin
         nxt_st.partner = page_q;
         nxt_st.partner[ACK_BIT] = 1'b1;
      end
      // partner page cleared on restart
      // restart wins over a capture in the same cycle: a page from the
      // old negotiation must not survive into the new one
      if (anr_rise(st_ff.restart_s2, st_ff.restart_s3)) begin
         nxt_st.partner = PARTNER_ABILITY_RST;
      end
   end

   // =====================================================
   // state register
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_ff.advert_reg  <= LOCAL_ADVERT_RST;
         st_ff.advert_live <= LOCAL_ADVERT_RST;
         st_ff.partner     <= PARTNER_ABILITY_RST;
         st_ff.rd_data     <= 16'h0000;
         st_ff.restart_s1  <= 1'b0;
         st_ff.restart_s2  <= 1'b0;
         st_ff.restart_s3  <= 1'b0;
         st_ff.pvalid_s1   <= 1'b0;
         st_ff.pvalid_s2   <= 1'b0;
         st_ff.pvalid_s3   <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // =====================================================
   // outputs
   assign reg_rdata_o   = st_ff.rd_data;
   assign advert_live_o = st_ff.advert_live;
   assign advert_reg_o  = st_ff.advert_reg;
   assign ability_fast_full_o = st_ff.advert_live[ABIL_MSB];
   assign ability_fast_half_o = st_ff.advert_live[ABIL_MSB-1];
   assign ability_slow_full_o = st_ff.advert_live[ABIL_LSB+1];
   assign ability_slow_half_o = st_ff.advert_live[ABIL_LSB];
endmodule

// ---- verification/anr_partner.sv ----
`timescale 1ns/1ns
module anr_partner (
   input  wire logic   sys_clk_i,
   input  wire logic   send_i,
   output logic        pv_o = 1'h0,
   output logic [15:0] pg_o = 16'h0000
);
   // idle page lines toggle so stale data never passes for a page
   always @(negedge sys_clk_i) begin
      pv_o <= send_i;
      pg_o <= send_i ? 16'h2DE1 : ~pg_o;
   end
endmodule

// ---- verification/anr_regs_properties.sv ----
`timescale 1ns/1ns
module anr_regs_properties
   import anr_pkg::*;
(
   input wire logic        sys_clk_i, nrst_i, reg_wr_i, an_restart_i,
   input wire logic [4:0]  reg_addr_i,
   input wire logic [15:0] reg_wdata_i, reg_rdata_o,
   input wire logic [15:0] advert_live_o, advert_reg_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_wr; reg_wr_i && reg_addr_i == 5'h04; endsequence
   property p_sel; advert_reg_o[4:0] == 5'h01; endproperty
   a_sel: assert property (p_sel) else $error("sel");
   property p_rsv; (advert_reg_o & 16'hDE1F) == 16'h0001; endproperty
   a_rsv: assert property (p_rsv) else $error("rsv");
   property p_wr;
      s_wr |=> advert_reg_o == ($past(reg_wdata_i) & 16'h21E0 | 16'h0001);
   endproperty
   a_wr: assert property (p_wr) else $error("wr");
   property p_keep;
      !(reg_wr_i && reg_addr_i == 5'h04) |=> $stable(advert_reg_o);
   endproperty
   a_keep: assert property (p_keep) else $error("keep");
   property p_hold; !an_restart_i [*5] |-> $stable(advert_live_o); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_go;
      $rose(an_restart_i) |-> ##[2:4] advert_live_o == advert_reg_o;
   endproperty
   a_go: assert property (p_go) else $error("go");
   property p_rd;
      reg_addr_i == 5'h04 && !reg_wr_i |=> reg_rdata_o == advert_reg_o;
   endproperty
   a_rd: assert property (p_rd) else $error("rd");
   property p_unm;
      reg_addr_i != 5'h04 && reg_addr_i != 5'h05 |=> reg_rdata_o == 16'h0000;
   endproperty
   a_unm: assert property (p_unm) else $error("unm");
endmodule
bind anr_regs anr_regs_properties anr_regs_properties_inst (.sys_clk_i,
   .nrst_i, .reg_wr_i, .an_restart_i, .reg_addr_i, .reg_wdata_i,
   .reg_rdata_o, .advert_live_o, .advert_reg_o);

// ---- verification/anr_regs_tb.sv ----
`timescale 1ns/1ns
module anr_regs_tb;
   logic sys_clk_i = 1'h0, nrst_i = 1'h0, reg_wr_i = 1'h0;
   logic an_restart_i = 1'h0, send = 1'h0, partner_valid_i;
   logic [4:0] reg_addr_i = 5'h00;
   logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, partner_page_i;
   logic [15:0] advert_live_o, advert_reg_o;
   logic [3:0] ab;
   int errors = 0, checks_done = 0, cyc = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   anr_regs anr_regs_inst (.sys_clk_i, .nrst_i, .reg_addr_i, .reg_wr_i,
      .reg_wdata_i, .reg_rdata_o, .an_restart_i, .partner_valid_i,
      .partner_page_i, .advert_live_o, .advert_reg_o,
      .ability_fast_full_o(ab[3]), .ability_fast_half_o(ab[2]),
      .ability_slow_full_o(ab[1]), .ability_slow_half_o(ab[0]));
   anr_partner anr_partner_inst (.sys_clk_i, .send_i(send),
      .pv_o(partner_valid_i), .pg_o(partner_page_i));
   always @(negedge sys_clk_i) if (++cyc == 900) results(1);
   task w(int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   task chk(string n, logic [15:0] s, e);
      checks_done++;
      if (s !== e) errors++;
      if (s !== e) $display("ERROR %s exp %h seen %h", n, e, s);
   endtask
   task wr(logic [4:0] a, logic [15:0] d);
      {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'h1};
      w(1);
      reg_wr_i = 1'h0;
      w(1);
   endtask
   task rd(logic [4:0] a, logic [15:0] e);
      reg_addr_i = a;
      w(1);
      chk("rdata", reg_rdata_o, e);
   endtask
   task results(int t);
      errors += t;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      w(16);
      nrst_i = 1'h1;
      chk("adv", advert_reg_o, 16'h01E1);
      chk("ab", {12'h000, ab}, 16'h000F);
      rd(5'h05, 16'h0000);
      $display("reset test done");
      wr(5'h04, 16'h0000);
      rd(5'h04, 16'h0001);
      wr(5'h04, 16'h0120);
      wr(5'h05, 16'hFFFF);
      rd(5'h04, 16'h0121);
      rd(5'h05, 16'h0000);
      rd(5'h1F, 16'h0000);
      chk("live", advert_live_o, 16'h01E1);
      $display("write test done");
      an_restart_i = 1'h1;
      w(6);
      an_restart_i = 1'h0;
      chk("ab", {12'h000, ab}, 16'h0009);
      chk("live", advert_live_o, 16'h0121);
      send = 1'h1;
      w(6);
      rd(5'h05, 16'h6DE1);
      $display("partner test done");
      results(0);
   end
endmodule
